// File: pkg/power_pkg.sv
package power_pkg;
    // One-hot power states
    typedef enum logic [6:0] {
        ST_NORMAL     = 7'h01,
        ST_HALT       = 7'h02,
        ST_STOP_GRANT = 7'h04,
        ST_SNOOP      = 7'h08,
        ST_SLEEP      = 7'h10,
        ST_DEEP_SLEEP = 7'h20,
        ST_PLL_SETTLE = 7'h40
    } power_state_e;

    // Registered clock and service enables
    typedef struct packed {
        logic core_clock_on;
        logic cache_clock_on;
        logic snoop_enable;
        logic irq_latch_enable;
        logic differential_mode;
    } clock_ctrl_s;

    localparam clock_ctrl_s CTRL_RESET = '{
        core_clock_on: 1'b0, cache_clock_on: 1'b1, snoop_enable: 1'b1,
        irq_latch_enable: 1'b1, differential_mode: 1'b0};

    localparam int CLK_HZ = 25_000_000;
    localparam int PLL_SETTLE_MS = 1;
    localparam int PLL_SETTLE_CYCLES_DEF = (PLL_SETTLE_MS * CLK_HZ + 999) / 1000;
    localparam int SETTLE_CNT_W = 16;

    // Sampled cycles without a change before a clock counts as stopped
    localparam int IDLE_CYCLES = 4;
    localparam int IDLE_CNT_W = 3;

    localparam int SELECT_CODE_W = 5;
    // Arbitrary default supply code
    localparam logic [SELECT_CODE_W-1:0] SELECT_CODE_DEFAULT = 5'h0A;
endpackage

// File: rtl/toggle_watch.sv
`timescale 1ns/1ps
module toggle_watch (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Watched level
    input wire logic level_in,
    // Toggling seen recently
    output logic active_out
);
    import power_pkg::*;

    logic prev;
    logic [IDLE_CNT_W-1:0] idle;
    logic next_prev;
    logic [IDLE_CNT_W-1:0] next_idle;

    always_comb begin
        next_prev = level_in;
        next_idle = idle;
        if (level_in != prev) begin
            next_idle = '0;
        end else if (idle != IDLE_CNT_W'(IDLE_CYCLES)) begin
            next_idle = idle + IDLE_CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            // Follow the pin in reset, so a pin idling high shows no false edge on release
            prev <= next_prev;
            idle <= IDLE_CNT_W'(IDLE_CYCLES);
        end else begin
            prev <= next_prev;
            idle <= next_idle;
        end
    end

    assign active_out = (idle != IDLE_CNT_W'(IDLE_CYCLES)) || (level_in != prev);
endmodule // toggle_watch

// File: rtl/clock_stop_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Deep Sleep from Sleep or PLL settling, clock stopped
// - Deep Sleep once bus clock unchanged for 4 sampled cycles
// - Sleep release returns to clock-stop granted
// - No snoops, no interrupt latching while sleeping
// - Halt and granted keep cache clock, snoops
// - Snoop state snoops cache like Normal
// - Cache clock on in Sleep, off Deep
// - Cache clock back only after PLL settles
// - Complement toggling selects differential clocking
// - Core and cache clocked from bus clock
// - Drive five supply select outputs
// - Stop-clock request enters clock-stop granted
// - Sleep request honoured only when granted
module clock_stop_ctrl #(
    parameter int PLL_SETTLE_CYCLES = power_pkg::PLL_SETTLE_CYCLES_DEF
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Bus clock pins, sampled
    input wire logic bus_clk_in,
    input wire logic bus_clk_comp_in,
    // Partner controls
    input wire logic stop_clock_request_n_in,
    input wire logic sleep_request_n_in,
    // Core events
    input wire logic halt_request_in,
    input wire logic wake_event_in,
    input wire logic snoop_request_in,
    input wire logic snoop_done_in,
    input wire logic interrupt_in,
    input wire logic interrupt_ack_in,
    // State and enables
    output power_pkg::power_state_e state_out,
    output power_pkg::clock_ctrl_s ctrl_out,
    output logic interrupt_pending_out,
    // Open-drain supply select, low enable drives pin low
    output logic [power_pkg::SELECT_CODE_W-1:0] voltage_select_code_out,
    output logic [power_pkg::SELECT_CODE_W-1:0] voltage_select_code_oe_n_out
);
    import power_pkg::*;

    localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = SETTLE_CNT_W'(PLL_SETTLE_CYCLES - 1);

    logic bus_active;
    logic comp_active;
    power_state_e state, next_state;
    clock_ctrl_s ctrl, next_ctrl;
    logic [SETTLE_CNT_W-1:0] settle, next_settle;
    logic from_halt, next_from_halt;
    logic irq_pending, next_irq_pending;
    logic stop_req;
    logic sleep_req;

    toggle_watch bus_watch (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .level_in(bus_clk_in),
        .active_out(bus_active)
    );

    toggle_watch comp_watch (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .level_in(bus_clk_comp_in),
        .active_out(comp_active)
    );

    assign stop_req = !stop_clock_request_n_in;
    assign sleep_req = !sleep_request_n_in;

    function automatic logic sleeping(input power_state_e s);
        return (s == ST_SLEEP) || (s == ST_DEEP_SLEEP) || (s == ST_PLL_SETTLE);
    endfunction

    // State sequencing
    always_comb begin
        next_state = state;
        next_settle = settle;
        next_from_halt = from_halt;
        case (state)
            ST_NORMAL: begin
                if (stop_req) begin
                    next_state = ST_STOP_GRANT;
                    next_from_halt = 1'b0;
                end else if (halt_request_in) begin
                    next_state = ST_HALT;
                end
            end
            ST_HALT: begin
                if (stop_req) begin
                    next_state = ST_STOP_GRANT;
                    next_from_halt = 1'b1;
                end else if (snoop_request_in) begin
                    next_state = ST_SNOOP;
                    next_from_halt = 1'b1;
                end else if (wake_event_in) begin
                    next_state = ST_NORMAL;
                end
            end
            ST_STOP_GRANT: begin
                if (!stop_req) begin
                    next_state = from_halt ? ST_HALT : ST_NORMAL;
                end else if (sleep_req) begin
                    next_state = ST_SLEEP;
                end else if (snoop_request_in) begin
                    next_state = ST_SNOOP;
                end
            end
            ST_SNOOP: begin
                if (snoop_done_in) begin
                    next_state = stop_req ? ST_STOP_GRANT : (from_halt ? ST_HALT : ST_NORMAL);
                end
            end
            ST_SLEEP: begin
                if (!bus_active) begin
                    next_state = ST_DEEP_SLEEP;
                end else if (!sleep_req) begin
                    next_state = ST_STOP_GRANT;
                end
            end
            ST_DEEP_SLEEP: begin
                next_settle = '0;
                if (bus_active) begin
                    next_state = ST_PLL_SETTLE;
                end
            end
            ST_PLL_SETTLE: begin
                if (!bus_active) begin
                    next_state = ST_DEEP_SLEEP;
                end else if (settle == SETTLE_LAST) begin
                    next_state = ST_SLEEP;
                end else begin
                    next_settle = settle + SETTLE_CNT_W'(1);
                end
            end
            default: begin
                next_state = ST_NORMAL;
            end
        endcase
    end

    // Enables follow the next state so they line up with it
    always_comb begin
        next_ctrl.core_clock_on = bus_active && (next_state == ST_NORMAL);
        next_ctrl.cache_clock_on = (next_state != ST_DEEP_SLEEP) && (next_state != ST_PLL_SETTLE);
        next_ctrl.snoop_enable = !sleeping(next_state) && (next_state != ST_SLEEP);
        next_ctrl.irq_latch_enable = !sleeping(next_state);
        next_ctrl.differential_mode = comp_active;
        next_irq_pending = irq_pending;
        if (interrupt_ack_in) begin
            next_irq_pending = 1'b0;
        end
        if (interrupt_in && ctrl.irq_latch_enable) begin
            next_irq_pending = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            state <= ST_NORMAL;
            ctrl <= CTRL_RESET;
            settle <= '0;
            from_halt <= 1'b0;
            irq_pending <= 1'b0;
        end else begin
            state <= next_state;
            ctrl <= next_ctrl;
            settle <= next_settle;
            from_halt <= next_from_halt;
            irq_pending <= next_irq_pending;
        end
    end

    assign state_out = state;
    assign ctrl_out = ctrl;
    assign interrupt_pending_out = irq_pending;
    assign voltage_select_code_out = '0;
    assign voltage_select_code_oe_n_out = SELECT_CODE_DEFAULT;

    // Checks
    sequence in_sleep_s;
        state == ST_SLEEP;
    endsequence

    sequence bus_stops_s;
        in_sleep_s ##0 !bus_active;
    endsequence

    sequence settle_done_s;
        state == ST_PLL_SETTLE && bus_active && settle == SETTLE_LAST;
    endsequence

    deep_entry_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        bus_stops_s |=> state == ST_DEEP_SLEEP ##0 !ctrl.cache_clock_on)
        else $error("Deep Sleep not entered when bus clock stopped");

    deep_origin_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (state == ST_DEEP_SLEEP && $past(state) != ST_DEEP_SLEEP)
        |-> ($past(state) == ST_SLEEP || $past(state) == ST_PLL_SETTLE))
        else $error("Deep Sleep entered from wrong state");

    sleep_gate_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (state == ST_NORMAL || state == ST_HALT) |=> state != ST_SLEEP)
        else $error("Sleep entered outside clock-stop granted");

    grant_entry_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (state == ST_NORMAL && stop_req) |=> state == ST_STOP_GRANT)
        else $error("Stop-clock request not granted");

    sleep_exit_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (in_sleep_s ##0 bus_active && !sleep_req) |=> state == ST_STOP_GRANT)
        else $error("Sleep release did not return to granted");

    settle_done_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        settle_done_s |=> in_sleep_s ##0 ctrl.cache_clock_on)
        else $error("Cache clock not back after settling");

    settle_hold_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (state == ST_DEEP_SLEEP ##1 state == ST_PLL_SETTLE && bus_active)
        |-> !ctrl.cache_clock_on && settle == '0)
        else $error("Settling started with cache clock running");

    quiet_sleep_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        sleeping(state) |-> !ctrl.snoop_enable && !ctrl.irq_latch_enable)
        else $error("Snoop or interrupt enabled while sleeping");

    grant_snoop_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (state == ST_HALT || state == ST_STOP_GRANT || state == ST_SNOOP)
        |-> ctrl.snoop_enable && ctrl.cache_clock_on)
        else $error("Snoop or cache clock lost in halt or granted");

    irq_hold_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (!ctrl.irq_latch_enable && !irq_pending) |=> !irq_pending)
        else $error("Interrupt latched while sleeping");

    diff_mode_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        ##1 ctrl.differential_mode == $past(comp_active))
        else $error("Clocking mode does not follow complement activity");
endmodule // clock_stop_ctrl

// File: bench/chipset_model.sv
`timescale 1ns/1ps
module chipset_model #(
    parameter int SETTLE_CYCLES = 20
) (
    // Clock
    input wire logic ref_clk_in,
    // Commands from the bench
    input wire logic clk_run_in,
    input wire logic diff_in,
    input wire logic stop_in,
    input wire logic sleep_in,
    // Pins toward the device
    output logic bus_clk_out,
    output logic bus_clk_comp_out,
    output logic interrupt_ctrl_clock_out,
    output logic stop_clock_request_n_out,
    output logic sleep_request_n_out,
    // Settling wait over
    output logic settled_out
);
    logic run_q = 1'b0;
    logic diff_q = 1'b0;
    logic stop_q = 1'b0;
    logic sleep_q = 1'b0;
    int settle_cnt = 0;

    initial begin
        bus_clk_out = 1'b0;
        bus_clk_comp_out = 1'b1;
        interrupt_ctrl_clock_out = 1'b0;
        stop_clock_request_n_out = 1'b1;
        sleep_request_n_out = 1'b1;
        settled_out = 1'b0;
    end

    // Commands taken at the edge, pins changed just after it
    always @(posedge ref_clk_in) begin
        {run_q, diff_q, stop_q, sleep_q} = {clk_run_in, diff_in, stop_in, sleep_in};
        #1;
        stop_clock_request_n_out = !stop_q;
        sleep_request_n_out = !sleep_q;
        if (run_q) begin
            bus_clk_out = !bus_clk_out;
        end
        bus_clk_comp_out = diff_q ? !bus_clk_out : 1'b1;
        interrupt_ctrl_clock_out = bus_clk_out;
        if (!run_q) begin
            settle_cnt = 0;
        end else if (settle_cnt < SETTLE_CYCLES) begin
            settle_cnt++;
        end
        settled_out = (settle_cnt >= SETTLE_CYCLES);
    end
endmodule // chipset_model

// File: bench/clock_stop_ctrl_tb.sv
`timescale 1ns/1ps
module clock_stop_ctrl_tb;
    import power_pkg::*;
    localparam int SETTLE = 20;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic run = 1'b0, diff = 1'b0, stop = 1'b0, sleep = 1'b0;
    logic halt = 1'b0, wake = 1'b0, snoop_req = 1'b0, snoop_done = 1'b0, irq = 1'b0, irq_ack = 1'b0;
    logic bus_clk, bus_comp, pic_clk, stop_n, sleep_n, settled, pending;
    power_state_e state_out;
    clock_ctrl_s ctrl_out;
    logic [SELECT_CODE_W-1:0] select_code, select_code_oe_n;
    int fails = 0, total_checks = 0, cycles = 0;

    always #20 ref_clk_in = !ref_clk_in;

    chipset_model #(.SETTLE_CYCLES(SETTLE)) chipset_model_i (.ref_clk_in(ref_clk_in), .clk_run_in(run),
        .diff_in(diff), .stop_in(stop), .sleep_in(sleep), .bus_clk_out(bus_clk), .bus_clk_comp_out(bus_comp),
        .interrupt_ctrl_clock_out(pic_clk), .stop_clock_request_n_out(stop_n), .sleep_request_n_out(sleep_n),
        .settled_out(settled));

    clock_stop_ctrl #(.PLL_SETTLE_CYCLES(SETTLE)) clock_stop_ctrl_i (.ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in), .bus_clk_in(bus_clk), .bus_clk_comp_in(bus_comp),
        .stop_clock_request_n_in(stop_n), .sleep_request_n_in(sleep_n), .halt_request_in(halt),
        .wake_event_in(wake), .snoop_request_in(snoop_req), .snoop_done_in(snoop_done), .interrupt_in(irq),
        .interrupt_ack_in(irq_ack), .state_out(state_out), .ctrl_out(ctrl_out), .interrupt_pending_out(pending),
        .voltage_select_code_out(select_code), .voltage_select_code_oe_n_out(select_code_oe_n));

    task automatic results();
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            results();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_st(input power_state_e s);
        int n;
        n = 0;
        while (state_out !== s && n < 40) begin
            step(1);
            n++;
        end
        chk(state_out, s);
    endtask

    task automatic test_reset();
        step(12);
        chk(state_out, ST_NORMAL);
        chk(ctrl_out, CTRL_RESET);
        chk(pending, 1'b0);
        chk(select_code_oe_n, SELECT_CODE_DEFAULT);
        chk(select_code, 5'h00);
        reset_n_in = 1'b1;
    endtask

    task automatic test_clocking();
        run = 1'b1;
        step(2);
        chk(ctrl_out.differential_mode, 1'b0);
        step(6);
        chk(ctrl_out.core_clock_on, 1'b1);
        chk(ctrl_out.differential_mode, 1'b0);
        diff = 1'b1;
        step(8);
        chk(ctrl_out.differential_mode, 1'b1);
    endtask

    task automatic test_halt_snoop();
        sleep = 1'b1;
        step(6);
        chk(state_out, ST_NORMAL);
        halt = 1'b1;
        step(1);
        halt = 1'b0;
        wait_st(ST_HALT);
        step(4);
        chk(state_out, ST_HALT);
        sleep = 1'b0;
        step(3);
        snoop_req = 1'b1;
        step(1);
        snoop_req = 1'b0;
        wait_st(ST_SNOOP);
        chk({ctrl_out.cache_clock_on, ctrl_out.snoop_enable}, 2'b11);
        snoop_done = 1'b1;
        step(1);
        snoop_done = 1'b0;
        wait_st(ST_HALT);
        chk({ctrl_out.cache_clock_on, ctrl_out.snoop_enable}, 2'b11);
        stop = 1'b1;
        wait_st(ST_STOP_GRANT);
        snoop_req = 1'b1;
        step(1);
        snoop_req = 1'b0;
        wait_st(ST_SNOOP);
        snoop_done = 1'b1;
        step(1);
        snoop_done = 1'b0;
        wait_st(ST_STOP_GRANT);
        chk({ctrl_out.cache_clock_on, ctrl_out.snoop_enable}, 2'b11);
        stop = 1'b0;
        wait_st(ST_HALT);
        wake = 1'b1;
        step(1);
        wake = 1'b0;
        wait_st(ST_NORMAL);
    endtask

    task automatic test_deep_sleep();
        stop = 1'b1;
        wait_st(ST_STOP_GRANT);
        chk({ctrl_out.cache_clock_on, ctrl_out.snoop_enable}, 2'b11);
        sleep = 1'b1;
        wait_st(ST_SLEEP);
        chk(ctrl_out.cache_clock_on, 1'b1);
        chk({ctrl_out.snoop_enable, ctrl_out.irq_latch_enable}, 2'b00);
        irq = 1'b1;
        step(1);
        irq = 1'b0;
        step(2);
        chk(pending, 1'b0);
        run = 1'b0; // Bus kept quiet until Deep Sleep is reached
        wait_st(ST_DEEP_SLEEP);
        chk(ctrl_out.cache_clock_on, 1'b0);
        run = 1'b1;
        wait_st(ST_PLL_SETTLE);
        step(SETTLE / 2);
        chk(state_out, ST_PLL_SETTLE);
        chk(ctrl_out.cache_clock_on, 1'b0);
        wait_st(ST_SLEEP);
        chk(ctrl_out.cache_clock_on, 1'b1);
        while (settled !== 1'b1) step(1);
        sleep = 1'b0;
        wait_st(ST_STOP_GRANT);
        stop = 1'b0;
        wait_st(ST_NORMAL);
    endtask

    task automatic test_irq();
        irq = 1'b1;
        step(1);
        irq = 1'b0;
        step(1);
        chk(pending, 1'b1);
        irq_ack = 1'b1;
        step(1);
        irq_ack = 1'b0;
        step(1);
        chk(pending, 1'b0);
    endtask

    initial begin
        test_reset();
        test_clocking();
        test_halt_snoop();
        test_deep_sleep();
        test_irq();
        results();
    end
endmodule // clock_stop_ctrl_tb
